// ---- hdl/rfc_regs.v ----
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "rfc_map.vh"
module rfc_regs (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Register port
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // Framer timing and events
  input wire t1_mode_in,
  input wire frame_tick_in,
  input wire bit_tick_in,
  input wire fbit_tick_in,
  input wire fbit_error_in,
  input wire fbit_is_fs_in,
  input wire mf_out_of_sync_in,
  input wire code_violation_in,
  input wire excess_zero_in,
  input wire b8zs_codeword_in,
  input wire remote_alarm_condition_in,
  input wire loss_of_frame_condition_in,
  // Line pins
  input wire line_rx_positive_in,
  input wire line_rx_negative_in,
  // Derived controls
  output reg count_latch_out,
  output reg [5:0] fifo_watermark_out,
  output reg [3:0] interleave_devices_out,
  output reg interleave_active_out,
  output reg frame_interleave_out,
  output reg [3:0] bus_position_out,
  output reg [3:0] spare_code_length_out,
  output reg bert_from_tx_out,
  output reg bert_take_fbit_out,
  output reg bert_active_out,
  output reg [7:0] bert_bit_use_out,
  output reg loss_of_signal_condition_out,
  output reg alarm_indication_condition_out
);

  function [7:0] sat_add;
    input [7:0] cnt;
    input [1:0] inc;
    reg [8:0] sum;
    begin
      sum = {1'b0, cnt} + {7'h00, inc};
      sat_add = sum[8] ? `RFC_CNT_MAX : sum[7:0];
    end
  endfunction

  function [2:0] ones6;
    input [5:0] v;
    integer i;
    begin
      ones6 = 3'h0;
      for (i = 0; i < 6; i = i + 1) begin
        ones6 = ones6 + {2'h0, v[i]};
      end
    end
  endfunction

  function [12:0] upd_period;
    input fast_sel;
    input t1_sel;
    begin
      if (!fast_sel) begin
        upd_period = `RFC_SEC_FRAMES;
      end else if (t1_sel) begin
        upd_period = `RFC_T1_FAST_FRAMES;
      end else begin
        upd_period = `RFC_E1_FAST_FRAMES;
      end
    end
  endfunction

  function wr_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = strobe && (addr == target);
    end
  endfunction

  function [3:0] plus_one;
    input [2:0] code;
    begin
      plus_one = {1'b0, code} + 4'h1;
    end
  endfunction

  reg [7:0] err_cfg;
  reg [7:0] fifo_ctl;
  reg [7:0] ibus_ctl;
  reg [7:0] spare_ctl;
  reg [7:0] bport_ctl;
  reg [7:0] supp_ctl;
  reg [7:0] alarm_stat;
  reg [7:0] event_stat;
  reg [7:0] cnt_fe;
  reg [7:0] cnt_mf;
  reg [7:0] cnt_lcv;
  reg [7:0] hold_fe;
  reg [7:0] hold_mf;
  reg [7:0] hold_lcv;
  reg [12:0] frame_cnt;
  reg man_prev;
  reg [3:0] cond_prev;
  reg [2:0] pos_sync;
  reg [2:0] neg_sync;
  reg pos_stable;
  reg neg_stable;
  reg [7:0] zero_run;
  reg [11:0] one_run;
  reg [5:0] fbit_hist;

  wire wr_error_counter_config = wr_hit(wr_in, addr_in, `RFC_ERROR_COUNTER_CONFIG_ADDR);
  wire wr_alarm = wr_hit(wr_in, addr_in, `RFC_ALARM_ADDR);
  wire wr_event = wr_hit(wr_in, addr_in, `RFC_EVENT_ADDR);
  wire manual = err_cfg[`RFC_ACC_MODE];
  wire fast = err_cfg[`RFC_UPD_SEL];
  wire [12:0] period = upd_period(fast, t1_mode_in);
  wire timer_hit = frame_tick_in && (frame_cnt + 13'h0001 >= period);
  wire man_rise = err_cfg[`RFC_MAN_LATCH] && !man_prev;
  wire latch_now = manual ? man_rise : timer_hit;

  // Ft or FPS error versus Fs error, as marked by the framer.
  wire ft_err = fbit_tick_in && fbit_error_in && !fbit_is_fs_in;
  wire fs_err = fbit_tick_in && fbit_error_in && fbit_is_fs_in;
  wire fe_inc = ft_err || (fs_err && err_cfg[`RFC_FS_EN]);
  wire mf_inc = (t1_mode_in && err_cfg[`RFC_MF_FN]) ?
    mf_out_of_sync_in : (ft_err || fs_err);
  wire ez_inc = excess_zero_in && err_cfg[`RFC_LCV_FN];
  wire [1:0] lcv_inc = {1'b0, code_violation_in} + {1'b0, ez_inc};

  wire line_zero = !pos_stable && !neg_stable;
  wire line_one = pos_stable ^ neg_stable;
  wire [7:0] zero_next = (zero_run == `RFC_CNT_MAX) ? zero_run :
    zero_run + 8'h01;
  wire [5:0] hist_next = {fbit_hist[4:0], ft_err};
  wire sef_hit = ft_err &&
    (ones6(hist_next) >= `RFC_SEF_ERRS);

  wire [3:0] cond_now = {remote_alarm_condition_in,
    alarm_indication_condition_out,
    loss_of_signal_condition_out,
    loss_of_frame_condition_in};
  wire [7:0] alarm_set = {cond_prev & ~cond_now,
    ~cond_prev & cond_now};
  wire [7:0] event_set = t1_mode_in ? {3'h0,
    bit_tick_in && line_zero && (zero_next == `RFC_Z8),
    bit_tick_in && line_zero && (zero_next == `RFC_Z16),
    sef_hit,
    b8zs_codeword_in,
    ft_err} : 8'h00;

  // Config writes. Bits outside the masks stay at reset value.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err_cfg <= `RFC_RST_VAL;
      fifo_ctl <= `RFC_RST_VAL;
      ibus_ctl <= `RFC_RST_VAL;
      spare_ctl <= `RFC_RST_VAL;
      bport_ctl <= `RFC_RST_VAL;
      supp_ctl <= `RFC_RST_VAL;
    end else if (wr_in) begin
      case (addr_in)
        `RFC_ERROR_COUNTER_CONFIG_ADDR: err_cfg <= wdata_in & `RFC_ERROR_COUNTER_CONFIG_MASK;
        `RFC_FIFO_ADDR: fifo_ctl <= wdata_in & `RFC_FIFO_MASK;
        `RFC_IBUS_ADDR: ibus_ctl <= wdata_in & `RFC_IBUS_MASK;
        `RFC_SPARE_ADDR: spare_ctl <= wdata_in & `RFC_SPARE_MASK;
        `RFC_BPORT_ADDR: bport_ctl <= wdata_in & `RFC_BPORT_MASK;
        `RFC_SUPP_ADDR: supp_ctl <= wdata_in;
        default: supp_ctl <= supp_ctl;
      endcase
    end
  end

  // Latched status. The set term is ored after the clear so it wins.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alarm_stat <= `RFC_RST_VAL;
      event_stat <= `RFC_RST_VAL;
      cond_prev <= 4'h0;
    end else begin
      cond_prev <= cond_now;
      alarm_stat <= (alarm_stat & ~(wr_alarm ? wdata_in : 8'h00))
        | alarm_set;
      event_stat <= (event_stat & ~(wr_event ? wdata_in : 8'h00))
        | event_set;
    end
  end

  // Error counters and their update timing.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frame_cnt <= 13'h0000;
      man_prev <= 1'b0;
      cnt_fe <= 8'h00;
      cnt_mf <= 8'h00;
      cnt_lcv <= 8'h00;
      hold_fe <= 8'h00;
      hold_mf <= 8'h00;
      hold_lcv <= 8'h00;
      count_latch_out <= 1'b0;
    end else begin
      man_prev <= err_cfg[`RFC_MAN_LATCH];
      if (manual || wr_error_counter_config) begin
        frame_cnt <= 13'h0000;
      end else if (frame_tick_in) begin
        frame_cnt <= timer_hit ? 13'h0000 : frame_cnt + 13'h0001;
      end
      count_latch_out <= latch_now;
      if (latch_now) begin
        // Counts from the latch cycle start the new interval.
        hold_fe <= cnt_fe;
        hold_mf <= cnt_mf;
        hold_lcv <= cnt_lcv;
        cnt_fe <= {7'h00, fe_inc};
        cnt_mf <= {7'h00, mf_inc};
        cnt_lcv <= {6'h00, lcv_inc};
      end else begin
        cnt_fe <= sat_add(cnt_fe, {1'b0, fe_inc});
        cnt_mf <= sat_add(cnt_mf, {1'b0, mf_inc});
        cnt_lcv <= sat_add(cnt_lcv, lcv_inc);
      end
    end
  end

  // Line pin synchronisers, a level is taken once stages two and three agree.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pos_sync <= 3'h0;
      neg_sync <= 3'h0;
      pos_stable <= 1'b0;
      neg_stable <= 1'b0;
    end else begin
      pos_sync <= {pos_sync[1:0], line_rx_positive_in};
      neg_sync <= {neg_sync[1:0], line_rx_negative_in};
      if (pos_sync[1] == pos_sync[2]) begin
        pos_stable <= pos_sync[2];
      end
      if (neg_sync[1] == neg_sync[2]) begin
        neg_stable <= neg_sync[2];
      end
    end
  end

  // Line monitor. A zero is a bit period with no mark on either wire.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      zero_run <= 8'h00;
      one_run <= 12'h000;
      fbit_hist <= 6'h00;
      loss_of_signal_condition_out <= 1'b0;
      alarm_indication_condition_out <= 1'b0;
    end else begin
      if (fbit_tick_in && !fbit_is_fs_in) begin
        fbit_hist <= hist_next;
      end
      if (bit_tick_in) begin
        if (line_zero) begin
          zero_run <= zero_next;
          one_run <= 12'h000;
          alarm_indication_condition_out <= 1'b0;
          if (zero_next >= `RFC_LOS_ZEROS) begin
            loss_of_signal_condition_out <= 1'b1;
          end
        end else if (line_one) begin
          zero_run <= 8'h00;
          loss_of_signal_condition_out <= 1'b0;
          if (one_run != 12'hFFF) begin
            one_run <= one_run + 12'h001;
          end
          // The ones run ignores framing, so only an unframed code gets here.
          if (one_run + 12'h001 >= `RFC_AIS_ONES) begin
            alarm_indication_condition_out <= 1'b1;
          end
        end
      end
    end
  end

  // Registered controls for the datapaths.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fifo_watermark_out <= 6'h04;
      interleave_devices_out <= 4'h2;
      interleave_active_out <= 1'b0;
      frame_interleave_out <= 1'b0;
      bus_position_out <= 4'h1;
      spare_code_length_out <= 4'h1;
      bert_from_tx_out <= 1'b0;
      bert_take_fbit_out <= 1'b0;
      bert_active_out <= 1'b0;
      bert_bit_use_out <= 8'h00;
    end else begin
      case (fifo_ctl[1:0])
        2'h0: fifo_watermark_out <= 6'h04;
        2'h1: fifo_watermark_out <= 6'h10;
        2'h2: fifo_watermark_out <= 6'h20;
        default: fifo_watermark_out <= 6'h30;
      endcase
      case (ibus_ctl[`RFC_IB_SIZE_HI:`RFC_IB_SIZE_LO])
        2'h0: interleave_devices_out <= 4'h2;
        2'h1: interleave_devices_out <= 4'h4;
        2'h2: interleave_devices_out <= 4'h8;
        default: interleave_devices_out <= 4'h0;
      endcase
      // A reserved size keeps the bus idle rather than guess a rate.
      interleave_active_out <= ibus_ctl[`RFC_IB_EN] &&
        (ibus_ctl[`RFC_IB_SIZE_HI:`RFC_IB_SIZE_LO] != 2'h3);
      frame_interleave_out <= ibus_ctl[`RFC_IB_MODE];
      bus_position_out <= plus_one(
        ibus_ctl[`RFC_IB_POS_HI:`RFC_IB_POS_LO]);
      spare_code_length_out <= plus_one(spare_ctl[2:0]);
      bert_from_tx_out <= bport_ctl[`RFC_BP_DIR];
      bert_take_fbit_out <= t1_mode_in &&
        bport_ctl[`RFC_BP_FRAMED];
      bert_active_out <= bport_ctl[`RFC_BP_EN];
      bert_bit_use_out <= bport_ctl[`RFC_BP_EN] ?
        ~supp_ctl : 8'h00;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `RFC_ERROR_COUNTER_CONFIG_ADDR: rdata_out <= err_cfg;
        `RFC_FIFO_ADDR: rdata_out <= fifo_ctl;
        `RFC_IBUS_ADDR: rdata_out <= ibus_ctl;
        `RFC_SPARE_ADDR: rdata_out <= spare_ctl;
        `RFC_BPORT_ADDR: rdata_out <= bport_ctl;
        `RFC_SUPP_ADDR: rdata_out <= supp_ctl;
        `RFC_ALARM_ADDR: rdata_out <= alarm_stat;
        `RFC_EVENT_ADDR: rdata_out <= event_stat;
        `RFC_CNT_FE_ADDR: rdata_out <= hold_fe;
        `RFC_CNT_MF_ADDR: rdata_out <= hold_mf;
        `RFC_CNT_LCV_ADDR: rdata_out <= hold_lcv;
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule // rfc_regs

// ---- hdl/rfc_map.vh ----
`ifndef RFC_MAP_VH
`define RFC_MAP_VH
// Register offsets.
`define RFC_ERROR_COUNTER_CONFIG_ADDR 8'h86
`define RFC_FIFO_ADDR 8'h87
`define RFC_IBUS_ADDR 8'h88
`define RFC_SPARE_ADDR 8'h89
`define RFC_BPORT_ADDR 8'h8A
`define RFC_SUPP_ADDR 8'h8B
`define RFC_ALARM_ADDR 8'h90
`define RFC_EVENT_ADDR 8'h91
`define RFC_CNT_FE_ADDR 8'hA0
`define RFC_CNT_MF_ADDR 8'hA1
`define RFC_CNT_LCV_ADDR 8'hA2
// Reset value and writable masks.
`define RFC_RST_VAL 8'h00
`define RFC_ERROR_COUNTER_CONFIG_MASK 8'h3F
`define RFC_FIFO_MASK 8'h03
`define RFC_IBUS_MASK 8'h7F
`define RFC_SPARE_MASK 8'h07
`define RFC_BPORT_MASK 8'h07
// Error counter configuration fields.
`define RFC_LCV_FN 0
`define RFC_MF_FN 1
`define RFC_FS_EN 2
`define RFC_ACC_MODE 3
`define RFC_UPD_SEL 4
`define RFC_MAN_LATCH 5
// Interleave bus fields.
`define RFC_IB_POS_HI 2
`define RFC_IB_POS_LO 0
`define RFC_IB_EN 3
`define RFC_IB_MODE 4
`define RFC_IB_SIZE_HI 6
`define RFC_IB_SIZE_LO 5
// BERT port fields.
`define RFC_BP_EN 0
`define RFC_BP_FRAMED 1
`define RFC_BP_DIR 2
// Update periods in frames of 125 us; one second is 8000 frames.
`define RFC_SEC_FRAMES 13'h1F40
`define RFC_T1_FAST_FRAMES 13'h014D
`define RFC_E1_FAST_FRAMES 13'h01F4
// Line monitor thresholds.
`define RFC_LOS_ZEROS 8'hC0
`define RFC_Z8 8'h08
`define RFC_Z16 8'h10
`define RFC_AIS_ONES 12'h800
`define RFC_SEF_ERRS 3'h2
`define RFC_CNT_MAX 8'hFF
`endif

// ---- tb/rfc_regs_monitor.sv ----
`timescale 1ns/1ps
module rfc_regs_monitor (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Register port
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  // Derived controls
  input wire [5:0] fifo_watermark_out,
  input wire [3:0] interleave_devices_out,
  input wire interleave_active_out,
  input wire frame_interleave_out,
  input wire [3:0] bus_position_out,
  input wire [3:0] spare_code_length_out,
  input wire bert_from_tx_out,
  input wire bert_active_out,
  input wire [7:0] bert_bit_use_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Controls follow a write two clocks later, so each write-triggered check looks back two.
  a_fifo_mark: assert property (wr_in && addr_in == 8'h87 |-> ##2
    fifo_watermark_out == ($past(wdata_in[1:0], 2) == 2'b00 ? 6'd4 :
    {$past(wdata_in[1:0], 2), 4'h0})) else $error("watermark wrong");
  a_fifo_range: assert property (fifo_watermark_out inside
    {6'd4, 6'd16, 6'd32, 6'd48}) else $error("watermark out of set");
  a_bus_place: assert property (wr_in && addr_in == 8'h88 |-> ##2
    bus_position_out == {1'b0, $past(wdata_in[2:0], 2)} + 4'd1)
    else $error("bus position wrong");
  a_bus_mode: assert property (wr_in && addr_in == 8'h88 |-> ##2
    frame_interleave_out == $past(wdata_in[4], 2))
    else $error("interleave mode wrong");
  a_bus_size: assert property (interleave_active_out |->
    interleave_devices_out inside {4'd2, 4'd4, 4'd8})
    else $error("active bus with bad size");
  a_spare_len: assert property (wr_in && addr_in == 8'h89 |-> ##2
    spare_code_length_out == {1'b0, $past(wdata_in[2:0], 2)} + 4'd1)
    else $error("spare length wrong");
  a_bert_port: assert property (wr_in && addr_in == 8'h8A |-> ##2
    bert_active_out == $past(wdata_in[0], 2) &&
    bert_from_tx_out == $past(wdata_in[2], 2)) else $error("bert port wrong");
  a_bert_mask: assert property (!bert_active_out |->
    bert_bit_use_out == 8'h00) else $error("bits used while port off");
endmodule // rfc_regs_monitor
bind rfc_regs rfc_regs_monitor mon (.clk_in, .sys_rst_in, .addr_in,
  .wdata_in, .wr_in, .fifo_watermark_out, .interleave_devices_out,
  .interleave_active_out, .frame_interleave_out, .bus_position_out,
  .spare_code_length_out, .bert_from_tx_out, .bert_active_out,
  .bert_bit_use_out);

// ---- tb/rfc_regs_test.sv ----
`timescale 1ns/1ps
module rfc_regs_test;
  logic clk_in = 0, sys_rst_in = 1, wr_in = 0, rd_in = 0, t1_mode_in = 1;
  logic fbit_error_in = 0, fbit_is_fs_in = 0, mf_out_of_sync_in = 0;
  logic remote_alarm_condition_in = 0, loss_of_frame_condition_in = 0;
  logic line_rx_positive_in = 1, line_rx_negative_in = 0;
  logic [5:0] pl = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, bert_bit_use_out;
  logic count_latch_out, interleave_active_out, frame_interleave_out;
  logic bert_from_tx_out, bert_take_fbit_out, bert_active_out;
  logic loss_of_signal_condition_out, alarm_indication_condition_out;
  logic [5:0] fifo_watermark_out;
  logic [3:0] interleave_devices_out, bus_position_out, spare_code_length_out;
  logic [3:0] dv;
  logic [7:0] ra [7] = '{8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8F};
  logic [7:0] rm [7] = '{8'h3F, 8'h03, 8'h7F, 8'h07, 8'h07, 8'hFF, 8'h00};
  int num_errors = 0, n_tests = 0, n_latch = 0, n0, i;
  // One-cycle event strobes share a vector so one task can pulse any of them.
  wire frame_tick_in = pl[0];
  wire bit_tick_in = pl[1];
  wire fbit_tick_in = pl[2];
  wire code_violation_in = pl[3];
  wire excess_zero_in = pl[4];
  wire b8zs_codeword_in = pl[5];
  rfc_regs dut (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .t1_mode_in, .frame_tick_in, .bit_tick_in, .fbit_tick_in,
    .fbit_error_in, .fbit_is_fs_in, .mf_out_of_sync_in, .code_violation_in,
    .excess_zero_in, .b8zs_codeword_in, .remote_alarm_condition_in,
    .loss_of_frame_condition_in, .line_rx_positive_in, .line_rx_negative_in,
    .count_latch_out, .fifo_watermark_out, .interleave_devices_out,
    .interleave_active_out, .frame_interleave_out, .bus_position_out,
    .spare_code_length_out, .bert_from_tx_out, .bert_take_fbit_out,
    .bert_active_out, .bert_bit_use_out, .loss_of_signal_condition_out,
    .alarm_indication_condition_out);
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (count_latch_out === 1'b1) n_latch <= n_latch + 1;
  task test_done;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk_in);
    wr_in <= 1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clk_in);
    rd_in <= 1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 0;
    #1 chk("rdata", rdata_out, e);
  endtask
  // Controls settle one clock after the write is taken.
  task set(input logic [7:0] a, d);
    wr(a, d);
    @(posedge clk_in);
    #1;
  endtask
  task pulse(input int k, n);
    repeat (n) begin
      @(posedge clk_in);
      pl[k] <= 1;
      @(posedge clk_in);
      pl[k] <= 0;
    end
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  initial begin
    #500000;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 0;
    #1 chk("rstA", {fifo_watermark_out, 2'b00}, 8'h10);
    chk("rstB", {interleave_devices_out, bus_position_out}, 8'h21);
    foreach (ra[k]) begin
      rd(ra[k], 8'h00);
      wr(ra[k], 8'hFF);
      rd(ra[k], rm[k]);
      wr(ra[k], 8'h00);
    end
    for (i = 0; i < 4; i++) begin
      set(8'h87, 8'(i));
      chk("wmark", 8'(fifo_watermark_out), i ? 8'(16 * i) : 8'd4);
    end
    for (i = 0; i < 8; i++) begin
      dv = (i % 4 == 3) ? 4'd0 : 4'(2 << (i % 4));
      set(8'h88, {1'b0, i[1:0], i[2], i[0], 3'(7 - i)});
      chk("ibus", {interleave_devices_out, interleave_active_out,
        frame_interleave_out, 2'b00}, {dv, i[0] && dv != 0, i[2], 2'b00});
      chk("pos", 8'(bus_position_out), 8'(8 - i));
      set(8'h89, 8'(i));
      chk("spare", 8'(spare_code_length_out), 8'(i + 1));
    end
    for (i = 0; i < 16; i++) begin
      t1_mode_in <= i[3];
      set(8'h8A, 8'(i % 8));
      chk("bport", {bert_from_tx_out, bert_take_fbit_out, bert_active_out},
        {i[2], i[3] & i[1], i[0]});
    end
    set(8'h8B, 8'hA5);
    chk("use", bert_bit_use_out, 8'h5A);
    set(8'h8A, 8'h00);
    chk("use", bert_bit_use_out, 8'h00);
    remote_alarm_condition_in <= 1;
    loss_of_frame_condition_in <= 1;
    rd(8'h90, 8'h09);
    remote_alarm_condition_in <= 0;
    loss_of_frame_condition_in <= 0;
    rd(8'h90, 8'h99);
    wr(8'h90, 8'h09);
    rd(8'h90, 8'h90);
    wr(8'h90, 8'hFF);
    rd(8'h90, 8'h00);
    line_rx_positive_in <= 0;
    repeat (6) @(posedge clk_in);
    pulse(1, 191);
    chk("los", 8'(loss_of_signal_condition_out), 8'h00);
    pulse(1, 1);
    chk("los", 8'(loss_of_signal_condition_out), 8'h01);
    rd(8'h91, 8'h18);
    line_rx_positive_in <= 1;
    repeat (6) @(posedge clk_in);
    pulse(1, 2047);
    chk("ais", 8'(alarm_indication_condition_out), 8'h00);
    pulse(1, 1);
    chk("ais", 8'(alarm_indication_condition_out), 8'h01);
    rd(8'h90, 8'h26);
    fbit_error_in <= 1;
    pulse(2, 1);
    rd(8'h91, 8'h19);
    pulse(2, 1);
    pulse(5, 1);
    rd(8'h91, 8'h1F);
    wr(8'h91, 8'hFF);
    rd(8'h91, 8'h00);
    fbit_is_fs_in <= 1;
    wr(8'h86, 8'h11);
    pulse(2, 2);
    fbit_is_fs_in <= 0;
    pulse(2, 1);
    fbit_error_in <= 0;
    pulse(3, 3);
    pulse(4, 2);
    n0 = n_latch;
    pulse(0, 332);
    chk("latch", 8'(n_latch - n0), 8'd0);
    pulse(0, 1);
    chk("latch", 8'(n_latch - n0), 8'd1);
    rd(8'hA2, 8'd5);
    rd(8'hA0, 8'd3);
    rd(8'hA1, 8'd5);
    t1_mode_in <= 0;
    wr(8'h86, 8'h10);
    pulse(3, 3);
    pulse(4, 2);
    n0 = n_latch;
    pulse(0, 499);
    chk("latch", 8'(n_latch - n0), 8'd0);
    pulse(0, 1);
    chk("latch", 8'(n_latch - n0), 8'd1);
    rd(8'hA2, 8'd3);
    t1_mode_in <= 1;
    wr(8'h86, 8'h0E);
    pulse(3, 4);
    fbit_error_in <= 1;
    fbit_is_fs_in <= 1;
    pulse(2, 1);
    fbit_is_fs_in <= 0;
    mf_out_of_sync_in <= 1;
    @(posedge clk_in);
    mf_out_of_sync_in <= 0;
    pulse(2, 1);
    fbit_error_in <= 0;
    n0 = n_latch;
    pulse(0, 600);
    chk("latch", 8'(n_latch - n0), 8'd0);
    wr(8'h86, 8'h2E);
    repeat (3) @(posedge clk_in);
    #1;
    chk("latch", 8'(n_latch - n0), 8'd1);
    rd(8'hA2, 8'd4);
    rd(8'hA0, 8'd2);
    rd(8'hA1, 8'd1);
    test_done;
  end
endmodule // rfc_regs_test
